/* File: fsp_pkg.sv */
// Package: register map, fields and timing for the flash self-program controller
package fsp_pkg;
  // Byte offsets on the classic Wishbone bus
  localparam logic [3:0]  ADDR_OP_CONTROL = 4'h0;
  localparam logic [3:0]  ADDR_UNLOCK_KEY = 4'h4;
  localparam logic [3:0]  ADDR_ADDR_HIGH  = 4'h8;
  localparam logic [3:0]  ADDR_ADDR_LOW   = 4'hc;
  localparam int          BUS_AW          = 4;
  // Operation control fields
  localparam int          CTL_START_BIT   = 15;
  localparam int          CTL_ERASE_BIT   = 6;
  localparam int          CTL_ERR_BIT     = 13;
  localparam logic [15:0] CTL_RESET       = 16'h0000;
  // Unlock key values
  localparam logic [7:0]  KEY_FIRST       = 8'h55;
  localparam logic [7:0]  KEY_SECOND      = 8'haa;
  // Address layout
  localparam int          TGT_W           = 24;
  localparam int          HIGH_W          = 8;
  localparam int          LOW_W           = 16;
  localparam int          WORD_W          = 24;
  // Flash array size kept small; page of 64 word addresses
  localparam int          FLASH_AW        = 10;
  localparam int          PAGE_SHIFT      = 6;
  localparam logic [WORD_W-1:0] ERASED_WORD = 24'hffffff;
  // Operation times, not given; neutral defaults
  localparam int          CLK_HZ          = 20_000_000;
  localparam int          ERASE_TIME_US   = 20;
  localparam int          PROG_TIME_US    = 10;
  localparam int          ERASE_CYC = (ERASE_TIME_US * (CLK_HZ / 1_000_000));
  localparam int          PROG_CYC  = (PROG_TIME_US * (CLK_HZ / 1_000_000));
  localparam int          CNT_W           = 16;
  typedef enum logic [1:0] {
    FSP_IDLE  = 2'b00,
    FSP_ERASE = 2'b01,
    FSP_PROG  = 2'b10
  } fsp_state_t;
  typedef enum logic [1:0] {
    KEY_NONE = 2'b00,
    KEY_HALF = 2'b01,
    KEY_OPEN = 2'b10
  } fsp_key_t;
endpackage

/* File: fsp_flash_if.sv */
`timescale 1ns/1ps
// Interface between the sequencer and the flash array
interface fsp_flash_if;
  logic                           erase_pg;
  logic                           prog_pair;
  logic [fsp_pkg::FLASH_AW-1:0]   addr;
  logic [fsp_pkg::WORD_W-1:0]     data_lo;
  logic [fsp_pkg::WORD_W-1:0]     data_hi;
  logic [fsp_pkg::FLASH_AW-1:0]   rd_addr;
  logic [fsp_pkg::WORD_W-1:0]     rd_data;
  modport ctl (output erase_pg, prog_pair, addr, data_lo, data_hi, rd_addr, input rd_data);
  modport mem (input erase_pg, prog_pair, addr, data_lo, data_hi, rd_addr, output rd_data);
endinterface

/* File: fsp_flash_array.sv */
`timescale 1ns/1ps
// Program flash array model: page erase and word-pair program
module fsp_flash_array
  import fsp_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  fsp_flash_if.mem  fl
);
  localparam int DEPTH = 1 << FLASH_AW;
  localparam int PAGE  = 1 << PAGE_SHIFT;
  logic [WORD_W-1:0] mem_r [DEPTH];
  logic [WORD_W-1:0] rd_r;

  // Each entry updated by one generate loop; erase hits the whole page
  for (genvar i = 0; i < DEPTH; i++) begin : g_cell
    // Entry index as a sized constant; a genvar cannot be part-selected
    localparam logic [FLASH_AW-1:0] IDX = FLASH_AW'(i);
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        mem_r[i] <= ERASED_WORD;
      end else if (fl.erase_pg &&
                   (fl.addr[FLASH_AW-1:PAGE_SHIFT] == IDX[FLASH_AW-1:PAGE_SHIFT])) begin
        mem_r[i] <= ERASED_WORD;
      end else if (fl.prog_pair && ({fl.addr[FLASH_AW-1:1], 1'b0} == IDX)) begin
        // Flash bits only go from one to zero
        mem_r[i] <= mem_r[i] & fl.data_lo;
      end else if (fl.prog_pair && ({fl.addr[FLASH_AW-1:1], 1'b1} == IDX)) begin
        mem_r[i] <= mem_r[i] & fl.data_hi;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_r <= '0;
    end else begin
      rd_r <= mem_r[fl.rd_addr];
    end
  end
  assign fl.rd_data = rd_r;
endmodule

/* File: fsp_ctrl.sv */
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
// Flash self-program controller: Wishbone registers, unlock, sequencer
// Functional notes
// RULE_01: Erase one page, program two words
// RULE_02: Stall processor while operation runs
// RULE_03: Start bit launches, hardware clears it
// RULE_04: Program pair at even word boundary
// RULE_05: Software erases page before programming
// RULE_06: Operation only after unlock sequence
// RULE_07: Software waits full programming time
// RULE_08: Software places two NOPs after start
// RULE_09: Key write-only; 0x55 then 0xAA
// RULE_10: High and low form 24-bit target
// RULE_11: High gives 8 bits, low 16
// RULE_12: Broken unlock or no unlock: no start
// RULE_13: Start bit reads one while busy
module fsp_ctrl
  import fsp_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [fsp_pkg::BUS_AW-1:0] wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  output logic                      wb_err_o,
  input  wire logic [fsp_pkg::TGT_W-1:0] rd_addr,
  output logic      [fsp_pkg::WORD_W-1:0] rd_data,
  input  wire logic [fsp_pkg::WORD_W-1:0] wr_data_lo,
  input  wire logic [fsp_pkg::WORD_W-1:0] wr_data_hi,
  output logic                      cpu_stall
);
  import fsp_pkg::*;

  typedef struct packed {
    fsp_state_t         state;
    fsp_key_t           key;
    logic               erase_sel;
    logic               op_err;
    logic [HIGH_W-1:0]  addr_high;
    logic [LOW_W-1:0]   addr_low;
    logic [CNT_W-1:0]   count;
    logic               ack;
    logic               err;
    logic [31:0]        rdata;
    logic               erase_pg;
    logic               prog_pair;
  } fsp_regs_t;

  fsp_regs_t s_r;
  fsp_regs_t s_nxt;

  fsp_flash_if fl ();

  fsp_flash_array u_array (
    .clk   (clk),
    .rst_n (rst_n),
    .fl    (fl)
  );

  logic              req;
  logic              wr_req;
  logic              busy;
  logic [TGT_W-1:0]  target;
  logic [15:0]       ctl_view;
  logic              lo_lane;
  logic              hi_lane;

  // Address registers joined into the target location
  assign target   = {s_r.addr_high, s_r.addr_low};
  assign busy     = (s_r.state != FSP_IDLE);
  assign req      = wb_cyc_i && wb_stb_i && !s_r.ack && !s_r.err;
  assign wr_req   = req && wb_we_i;
  assign lo_lane  = wb_sel_i[0];
  assign hi_lane  = wb_sel_i[1];

  // RULE_13: start reads busy
  always_comb begin
    ctl_view = CTL_RESET;
    ctl_view[CTL_START_BIT] = busy;
    ctl_view[CTL_ERR_BIT]   = s_r.op_err;
    ctl_view[CTL_ERASE_BIT] = s_r.erase_sel;
  end

  always_comb begin
    s_nxt           = s_r;
    s_nxt.ack       = 1'b0;
    s_nxt.err       = 1'b0;
    s_nxt.erase_pg  = 1'b0;
    s_nxt.prog_pair = 1'b0;

    if (req) begin
      s_nxt.rdata = '0;
      unique case (wb_adr_i)
        ADDR_OP_CONTROL: begin
          s_nxt.ack   = 1'b1;
          s_nxt.rdata = {16'h0000, ctl_view};
          if (wb_we_i && !busy) begin
            if (lo_lane) begin
              s_nxt.erase_sel = wb_dat_i[CTL_ERASE_BIT];
            end
            if (hi_lane && wb_dat_i[CTL_ERR_BIT]) begin
              s_nxt.op_err = 1'b0;
            end
            if (hi_lane && wb_dat_i[CTL_START_BIT]) begin
              // RULE_06: launch only when unlocked
              if (s_r.key == KEY_OPEN) begin
                s_nxt.count = '0;
                s_nxt.op_err = 1'b0;
                if (lo_lane ? wb_dat_i[CTL_ERASE_BIT] : s_r.erase_sel) begin
                  s_nxt.state = FSP_ERASE;
                end else begin
                  s_nxt.state = FSP_PROG;
                end
              end else begin
                // RULE_12: refuse start, flag error
                s_nxt.op_err = 1'b1;
              end
            end
          end
        end
        ADDR_UNLOCK_KEY: begin
          // RULE_09: key write-only, reads zero
          s_nxt.ack = 1'b1;
          if (wb_we_i && lo_lane) begin
            if (wb_dat_i[7:0] == KEY_FIRST) begin
              s_nxt.key = KEY_HALF;
            end else if (wb_dat_i[7:0] == KEY_SECOND && s_r.key == KEY_HALF) begin
              s_nxt.key = KEY_OPEN;
            end else begin
              s_nxt.key = KEY_NONE;
            end
          end
        end
        ADDR_ADDR_HIGH: begin
          s_nxt.ack   = 1'b1;
          s_nxt.rdata = {24'h000000, s_r.addr_high};
          // RULE_11: upper eight bits
          if (wb_we_i && lo_lane && !busy) begin
            s_nxt.addr_high = wb_dat_i[HIGH_W-1:0];
          end
        end
        ADDR_ADDR_LOW: begin
          s_nxt.ack   = 1'b1;
          s_nxt.rdata = {16'h0000, s_r.addr_low};
          // RULE_11: lower sixteen bits
          if (wb_we_i && !busy) begin
            if (lo_lane) begin
              s_nxt.addr_low[7:0] = wb_dat_i[7:0];
            end
            if (hi_lane) begin
              s_nxt.addr_low[15:8] = wb_dat_i[15:8];
            end
          end
        end
        default: begin
          s_nxt.err = 1'b1;
        end
      endcase
      // RULE_12: other write breaks unlock
      if (wr_req && wb_adr_i != ADDR_UNLOCK_KEY) begin
        s_nxt.key = KEY_NONE;
      end
    end

    unique case (s_r.state)
      FSP_IDLE: begin
      end
      FSP_ERASE: begin
        s_nxt.key   = KEY_NONE;
        s_nxt.count = s_r.count + 1'b1;
        // RULE_01: whole page at end of time
        if (s_r.count == CNT_W'(ERASE_CYC - 1)) begin
          s_nxt.erase_pg = 1'b1;
          // RULE_03: self-clear start
          s_nxt.state    = FSP_IDLE;
        end
      end
      FSP_PROG: begin
        s_nxt.key   = KEY_NONE;
        s_nxt.count = s_r.count + 1'b1;
        // RULE_04: pair written at even word
        if (s_r.count == CNT_W'(PROG_CYC - 1)) begin
          s_nxt.prog_pair = 1'b1;
          // RULE_03: self-clear start
          s_nxt.state     = FSP_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{state: FSP_IDLE, key: KEY_NONE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // RULE_10: target picks word or page
  assign fl.erase_pg  = s_r.erase_pg;
  assign fl.prog_pair = s_r.prog_pair;
  assign fl.addr      = target[FLASH_AW:1];
  assign fl.data_lo   = wr_data_lo;
  assign fl.data_hi   = wr_data_hi;
  assign fl.rd_addr   = rd_addr[FLASH_AW:1];
  assign rd_data      = fl.rd_data;

  // RULE_02: stall while busy
  assign cpu_stall = busy;
  assign wb_ack_o  = s_r.ack;
  assign wb_err_o  = s_r.err;
  assign wb_dat_o  = s_r.rdata;
endmodule

/* File: fsp_ctrl_monitor.sv */
// Bus and sequencer checks for the flash self-program controller
`timescale 1ns/1ps
module fsp_ctrl_monitor
  import fsp_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [BUS_AW-1:0] wb_adr_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic              wb_err_o,
  input wire logic              cpu_stall
);
  logic [15:0] run_r;
  logic        req;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  // Length of the current stall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_r <= 16'h0000;
    end else begin
      run_r <= cpu_stall ? run_r + 16'h0001 : 16'h0000;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held too long");
  property p_ack_resp; req && wb_adr_i[1:0] == 2'b00 |=> wb_ack_o && !wb_err_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("mapped access not acked");
  property p_err_resp; req && wb_adr_i[1:0] != 2'b00 |=> wb_err_o && !wb_ack_o; endproperty
  a_err_resp: assert property (p_err_resp) else $error("unmapped access not refused");
  property p_ans_cause; wb_ack_o || wb_err_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ans_cause: assert property (p_ans_cause) else $error("answer without request");
  property p_stall_len; $fell(cpu_stall) |->
    run_r inside {[PROG_CYC:PROG_CYC+2], [ERASE_CYC:ERASE_CYC+2]}; endproperty
  a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
  property p_stall_src; $rose(cpu_stall) |-> wb_ack_o && wb_we_i &&
    wb_adr_i == ADDR_OP_CONTROL && wb_dat_i[CTL_START_BIT]; endproperty
  a_stall_src: assert property (p_stall_src) else $error("stall without start");
  property p_busy_rd; wb_ack_o && !wb_we_i && wb_adr_i == ADDR_OP_CONTROL |->
    wb_dat_o[CTL_START_BIT] == $past(cpu_stall); endproperty
  a_busy_rd: assert property (p_busy_rd) else $error("start bit not busy");
  property p_key_rd; wb_ack_o && !wb_we_i && wb_adr_i == ADDR_UNLOCK_KEY |->
    wb_dat_o == 32'h0000_0000; endproperty
  a_key_rd: assert property (p_key_rd) else $error("key readable");
endmodule
bind fsp_ctrl fsp_ctrl_monitor mon_u (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .cpu_stall);

/* File: tb.sv */
// Self-checking bench for the flash self-program controller
`timescale 1ns/1ps
module tb;
  import fsp_pkg::*;
  logic              clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
  logic              cpu_stall, er;
  logic [BUS_AW-1:0] wb_adr_i;
  logic [3:0]        wb_sel_i;
  logic [31:0]       wb_dat_i, wb_dat_o, q;
  logic [TGT_W-1:0]  rd_addr;
  logic [WORD_W-1:0] rd_data, wr_data_lo, wr_data_hi;
  int                n_mismatch, samples_checked, cyc_n;
  fsp_ctrl dut_u (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .rd_addr, .rd_data, .wr_data_lo,
    .wr_data_hi, .cpu_stall);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // One classic cycle; waits for ack or err under a bound
  task automatic xfer(input logic we, input logic [3:0] a, input logic [31:0] d);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_sel_i <= 4'h3;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
    q  = wb_dat_o;
    er = wb_err_o;
    chk(n < 20, "bus hang");
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk);
  endtask
  task unlock;
    xfer(1'b1, ADDR_UNLOCK_KEY, {24'h0, KEY_FIRST});
    xfer(1'b1, ADDR_UNLOCK_KEY, {24'h0, KEY_SECOND});
  endtask
  // Unlock, launch, idle two slots, poll until done; t is the operation time
  task automatic run_op(input logic [31:0] d, input int t);
    int n;
    int c0;
    unlock();
    c0 = cyc_n;
    xfer(1'b1, ADDR_OP_CONTROL, d);
    chk(cpu_stall === 1'b1, "no stall");
    repeat (2) @(posedge clk);
    n = 0;
    do begin
      xfer(1'b0, ADDR_OP_CONTROL, 32'h0);
      n++;
    end while (q[CTL_START_BIT] === 1'b1 && n < 300);
    chk(n > 1, "start bit not busy");
    chk(q[CTL_START_BIT] === 1'b0 && cpu_stall === 1'b0, "not cleared");
    chk(cyc_n - c0 >= t && cyc_n - c0 <= t + 12, "stall time");
  endtask
  task automatic rd_chk(input logic [23:0] a, input logic [23:0] e);
    rd_addr <= a;
    repeat (2) @(posedge clk);
    chk(rd_data === e, "flash word");
  endtask
  task t_regs;
    xfer(1'b0, ADDR_OP_CONTROL, 32'h0);
    chk(q === {16'h0, CTL_RESET}, "control reset");
    xfer(1'b0, ADDR_UNLOCK_KEY, 32'h0);
    chk(q === 32'h0, "key read");
    xfer(1'b1, ADDR_ADDR_HIGH, 32'h0000_005a);
    xfer(1'b1, ADDR_ADDR_LOW, 32'h0000_beef);
    xfer(1'b0, ADDR_ADDR_HIGH, 32'h0);
    chk(q === 32'h0000_005a, "high address");
    xfer(1'b0, ADDR_ADDR_LOW, 32'h0);
    chk(q === 32'h0000_beef, "low address");
    xfer(1'b0, 4'h2, 32'h0);
    chk(er === 1'b1, "unmapped");
    $display("registers done");
  endtask
  task t_prog;
    wr_data_lo <= 24'h123456;
    wr_data_hi <= 24'h789abc;
    xfer(1'b1, ADDR_ADDR_HIGH, 32'h0);
    xfer(1'b1, ADDR_ADDR_LOW, 32'h0000_0006);
    run_op(32'h0000_8040, ERASE_CYC);
    run_op(32'h0000_8000, PROG_CYC);
    rd_chk(24'h000004, 24'h123456);
    rd_chk(24'h000006, 24'h789abc);
    rd_chk(24'h000002, ERASED_WORD);
    rd_chk(24'h000008, ERASED_WORD);
    $display("program done");
  endtask
  task t_erase;
    run_op(32'h0000_8040, ERASE_CYC);
    rd_chk(24'h000004, ERASED_WORD);
    rd_chk(24'h000006, ERASED_WORD);
    $display("erase done");
  endtask
  task t_bad;
    xfer(1'b1, ADDR_UNLOCK_KEY, {24'h0, KEY_FIRST});
    xfer(1'b1, ADDR_ADDR_LOW, 32'h0000_0006);
    xfer(1'b1, ADDR_UNLOCK_KEY, {24'h0, KEY_SECOND});
    xfer(1'b1, ADDR_OP_CONTROL, 32'h0000_8000);
    chk(cpu_stall === 1'b0, "broken unlock started");
    xfer(1'b1, ADDR_OP_CONTROL, 32'h0000_8000);
    chk(cpu_stall === 1'b0, "start without unlock");
    xfer(1'b0, ADDR_OP_CONTROL, 32'h0);
    chk(q[CTL_ERR_BIT] === 1'b1, "error bit");
    xfer(1'b1, ADDR_OP_CONTROL, 32'h0000_2000);
    xfer(1'b0, ADDR_OP_CONTROL, 32'h0);
    chk(q[CTL_ERR_BIT] === 1'b0, "error bit clear");
    rd_chk(24'h000004, ERASED_WORD);
    $display("refusals done");
  endtask
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 4000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'h3;
    wb_dat_i = 32'h0;
    rd_addr = 24'h0;
    wr_data_lo = 24'h0;
    wr_data_hi = 24'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_prog();
    t_erase();
    t_bad();
    summarize();
  end
endmodule
